// [core/isolated_input_conditioner.sv]
//
// Overview of operation
// (RL1) eight independent conditioned input channels
// (RL2) global index is offset plus channel; the code only holds offset_reg for readback and forms no index
// (RL3) sample and evaluate every 5 ms
// (RL4) polarity selects reported level when energized
// (RL5) activation threshold 16-200 V, default 88
// (RL6) above activation level energizes the channel
// (RL7) below release level de-energizes, default 60
// (RL8) rising change waits pick-up delay
// (RL9) falling change waits drop-off delay
// (RL10) ac mode adds 30 ms drop delay
// (RL11) ac mode release is tenth of pickup
// (RL12) 32-bit counter of reported rising edges
// (RL13) clear command zeroes channel counter
// (RL14) present voltage readable in millivolts
// (RL15) between thresholds keep previous state
// (RL16) reverting raw state restarts qualification
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`include "iic_params.svh"
module isolated_input_conditioner #(
	parameter int CHANNELS = 8,
	parameter int SCAN_CYC = `IIC_SCAN_CYC
) (
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// measured channel voltages, mV
	input  wire iic_pkg::mvolt_t       voltIn [CHANNELS],
	// conditioned states
	output logic      [CHANNELS-1:0]   binaryInputChannel,
	output logic                       irq
);
	import iic_pkg::*;
	logic [23:0]         scan_reg;
	logic                scanTick;
	logic [CHANNELS-1:0] pol_reg, ac_reg, clr_reg, rise, state;
	volt_t               pick_reg [CHANNELS];
	volt_t               drop_reg [CHANNELS];
	dly_t                pud_reg  [CHANNELS];
	dly_t                dod_reg  [CHANNELS];
	mvolt_t              volt_reg [CHANNELS];
	word_t               cnt      [CHANNELS];
	logic [7:0]          stat_reg, mask_reg;
	logic [15:0]         offset_reg;
	logic                wrEn, rdEn;
	logic [31:0]         rdData;
	logic                rdOk;

	////////////////////////////////////////////////////////////////////////
	// scan timer
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			scan_reg <= 24'h0;
		end else if (scan_reg == 24'(SCAN_CYC - 1)) begin
			scan_reg <= 24'h0; // RL3
		end else begin
			scan_reg <= scan_reg + 24'h1;
		end
	end
	assign scanTick = (scan_reg == 24'(SCAN_CYC - 1));

	////////////////////////////////////////////////////////////////////////
	// apb, zero wait state
	assign wrEn = psel & penable & pwrite;
	assign rdEn = psel & penable & ~pwrite;

	function automatic logic inBank(input logic [11:0] a, input logic [11:0] base);
		inBank = (a[11:6] == base[11:6]) && (a[5] == 1'b0) && (a[1:0] == 2'b00);
	endfunction : inBank

	function automatic int chOf(input logic [11:0] a);
		chOf = int'(a[4:2]);
	endfunction : chOf

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pol_reg    <= '0;
			ac_reg     <= '0;
			offset_reg <= 16'h0;
			mask_reg   <= 8'h0;
			for (int i = 0; i < CHANNELS; i++) begin
				pick_reg[i] <= `IIC_PICKUP_RST; // RL5
				drop_reg[i] <= `IIC_DROPOUT_RST; // RL7
				pud_reg[i]  <= `IIC_DLY_RST;
				dod_reg[i]  <= `IIC_DLY_RST;
			end
		end else if (wrEn) begin
			if (inBank(paddr, `IIC_CTRL_BASE)) begin
				pol_reg[chOf(paddr)] <= pwdata[`IIC_CTRL_POL_BIT]; // RL4
				ac_reg[chOf(paddr)]  <= pwdata[`IIC_CTRL_AC_BIT]; // RL10
			end
			if (inBank(paddr, `IIC_PICKUP_BASE)) begin
				pick_reg[chOf(paddr)] <= clampV(pwdata[11:0], 12'd160); // RL5
			end
			if (inBank(paddr, `IIC_DROPOUT_BASE)) begin
				drop_reg[chOf(paddr)] <= clampV(pwdata[11:0], 12'd100); // RL7
			end
			if (inBank(paddr, `IIC_PUDLY_BASE)) begin
				pud_reg[chOf(paddr)] <= clampD(pwdata[20:0]); // RL8
			end
			if (inBank(paddr, `IIC_DODLY_BASE)) begin
				dod_reg[chOf(paddr)] <= clampD(pwdata[20:0]); // RL9
			end
			if (paddr == `IIC_IRQ_MASK_OFF) begin
				mask_reg <= pwdata[7:0];
			end
			if (paddr == `IIC_OFFSET_OFF) begin
				offset_reg <= pwdata[15:0]; // RL2
			end
		end
	end

	function automatic volt_t clampV(input logic [11:0] v, input logic [11:0] lo);
		if (v < lo) begin
			clampV = lo;
		end else if (v > 12'd2000) begin
			clampV = 12'd2000;
		end else begin
			clampV = v;
		end
	endfunction : clampV

	function automatic dly_t clampD(input logic [20:0] d);
		clampD = (d > `IIC_DLY_MAX) ? `IIC_DLY_MAX : d;
	endfunction : clampD

	// clear command is a one-cycle pulse per written bit
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			clr_reg <= '0;
		end else if (wrEn && paddr == `IIC_CLEAR_OFF) begin
			clr_reg <= pwdata[CHANNELS-1:0]; // RL13
		end else begin
			clr_reg <= '0;
		end
	end

	// voltage sampled once per scan so readback matches evaluation
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < CHANNELS; i++) begin
				volt_reg[i] <= 19'h0;
			end
		end else if (scanTick) begin
			for (int i = 0; i < CHANNELS; i++) begin
				volt_reg[i] <= voltIn[i]; // RL14
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// channels
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : gCh
			channel_qualifier uQual ( // RL1
				.core_clk     (core_clk),
				.rst          (rst),
				.scanTick     (scanTick),
				.polaritySel  (pol_reg[g]),
				.acOption     (ac_reg[g]),
				.pickupLevel  (pick_reg[g]),
				.dropoutLevel (drop_reg[g]),
				.pickupTime   (pud_reg[g]),
				.dropoutTime  (dod_reg[g]),
				.voltNow      (volt_reg[g]),
				.countClear   (clr_reg[g]),
				.stateOut     (state[g]),
				.risePulse    (rise[g]),
				.countOut     (cnt[g])
			);
		end
	endgenerate

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			binaryInputChannel <= '0;
		end else begin
			binaryInputChannel <= state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt: rising events, read clears, set wins
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stat_reg <= 8'h0;
		end else if (rdEn && paddr == `IIC_IRQ_STAT_OFF) begin
			stat_reg <= rise;
		end else begin
			stat_reg <= stat_reg | rise;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_reg & mask_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux
	always_comb begin
		rdData = 32'h0;
		rdOk   = 1'b1;
		if (inBank(paddr, `IIC_CTRL_BASE)) begin
			rdData = {30'h0, ac_reg[chOf(paddr)], pol_reg[chOf(paddr)]};
		end else if (inBank(paddr, `IIC_PICKUP_BASE)) begin
			rdData = {20'h0, pick_reg[chOf(paddr)]};
		end else if (inBank(paddr, `IIC_DROPOUT_BASE)) begin
			rdData = {20'h0, drop_reg[chOf(paddr)]};
		end else if (inBank(paddr, `IIC_PUDLY_BASE)) begin
			rdData = {11'h0, pud_reg[chOf(paddr)]};
		end else if (inBank(paddr, `IIC_DODLY_BASE)) begin
			rdData = {11'h0, dod_reg[chOf(paddr)]};
		end else if (inBank(paddr, `IIC_COUNT_BASE)) begin
			rdData = cnt[chOf(paddr)]; // RL12
		end else if (inBank(paddr, `IIC_VOLT_BASE)) begin
			rdData = {13'h0, volt_reg[chOf(paddr)]}; // RL14
		end else if (paddr == `IIC_STATE_OFF) begin
			rdData = {24'h0, state};
		end else if (paddr == `IIC_IRQ_STAT_OFF) begin
			rdData = {24'h0, stat_reg};
		end else if (paddr == `IIC_IRQ_MASK_OFF) begin
			rdData = {24'h0, mask_reg};
		end else if (paddr == `IIC_OFFSET_OFF) begin
			rdData = {16'h0, offset_reg};
		end else if (paddr == `IIC_CLEAR_OFF) begin
			rdData = 32'h0;
		end else begin
			rdOk = 1'b0;
		end
	end

	// answer registered: pready rises with the first cycle of the access phase
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			prdata  <= (psel & ~penable & ~pwrite) ? rdData : 32'h0;
			pslverr <= psel & ~penable & ~rdOk;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence apbSetup;
		psel && !penable;
	endsequence
	sequence apbAccess;
		psel && penable && pready;
	endsequence
	// a scan edge without a tick; the output lags state by one cycle
	sequence quietScan;
		!scanTick ##1 1'b1;
	endsequence
	property scanPeriod;
		@(posedge core_clk) disable iff (rst) scanTick |=> !scanTick;
	endproperty
	property readyAnswer;
		@(posedge core_clk) disable iff (rst) apbSetup |=> pready;
	endproperty
	property readyOnce;
		@(posedge core_clk) disable iff (rst) apbSetup ##1 apbAccess |=> !pready;
	endproperty
	property stateOnScan;
		@(posedge core_clk) disable iff (rst) quietScan |=> $stable(binaryInputChannel);
	endproperty
	scan_period_a: assert property (scanPeriod) else $error("scan tick too close"); // RL3
	irq_level_a: assert property (@(posedge core_clk) disable iff (rst)
		(|(stat_reg & mask_reg)) |=> irq) else $error("irq missed");
	irq_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
		!(|(stat_reg & mask_reg)) |=> !irq) else $error("irq without masked event");
	stat_keep_a: assert property (@(posedge core_clk) disable iff (rst)
		(|rise) |=> (stat_reg & $past(rise)) == $past(rise)) else $error("event lost");
	ready_timing_a: assert property (readyAnswer)
		else $error("pready late");
	ready_single_a: assert property (readyOnce)
		else $error("pready held too long");
	unmapped_err_a: assert property (@(posedge core_clk) disable iff (rst)
		pslverr |-> pready) else $error("error without ready");
	state_scan_a: assert property (stateOnScan) else $error("state moved off scan"); // RL3
	clear_pulse_a: assert property (@(posedge core_clk) disable iff (rst) // RL13
		(wrEn && paddr == `IIC_CLEAR_OFF) |=> clr_reg == $past(pwdata[CHANNELS-1:0]))
		else $error("clear pulse lost");
	state_sync_a: assert property (@(posedge core_clk) disable iff (rst)
		1'b1 |=> binaryInputChannel == $past(state)) else $error("state out stale");
endmodule : isolated_input_conditioner

// [core/iic_params.svh]
`ifndef IIC_PARAMS_SVH
`define IIC_PARAMS_SVH
// register byte addresses (word per channel where indexed)
`define IIC_CTRL_BASE      12'h000
`define IIC_PICKUP_BASE    12'h040
`define IIC_DROPOUT_BASE   12'h080
`define IIC_PUDLY_BASE     12'h0c0
`define IIC_DODLY_BASE     12'h100
`define IIC_COUNT_BASE     12'h140
`define IIC_VOLT_BASE      12'h180
`define IIC_STATE_OFF      12'h1c0
`define IIC_CLEAR_OFF      12'h1c4
`define IIC_IRQ_STAT_OFF   12'h1c8
`define IIC_IRQ_MASK_OFF   12'h1cc
`define IIC_OFFSET_OFF     12'h1d0
// control word fields
`define IIC_CTRL_POL_BIT   0
`define IIC_CTRL_AC_BIT    1
// reset values, voltages in 0.1 V units, delays in ms
`define IIC_PICKUP_RST     12'h370
`define IIC_DROPOUT_RST    12'h258
`define IIC_DLY_RST        21'h000000
`define IIC_DLY_MAX        21'h1b7740
// timing
`define IIC_CLK_HZ         40000000
`define IIC_SCAN_MS        5
`define IIC_SCAN_CYC       (`IIC_CLK_HZ / 1000 * `IIC_SCAN_MS)
`define IIC_AC_EXTRA_MS    30
`endif

// [core/iic_pkg.sv]
package iic_pkg;
	typedef logic [11:0] volt_t;
	typedef logic [20:0] dly_t;
	typedef logic [31:0] word_t;
	typedef logic [18:0] mvolt_t;
endpackage : iic_pkg

// [core/channel_qualifier.sv]
`timescale 1ns/100ps
`include "iic_params.svh"
module channel_qualifier (
	// timing
	input  wire logic            core_clk,
	input  wire logic            rst,
	input  wire logic            scanTick,
	// settings
	input  wire logic            polaritySel,
	input  wire logic            acOption,
	input  wire iic_pkg::volt_t  pickupLevel,
	input  wire iic_pkg::volt_t  dropoutLevel,
	input  wire iic_pkg::dly_t   pickupTime,
	input  wire iic_pkg::dly_t   dropoutTime,
	input  wire iic_pkg::mvolt_t voltNow,
	input  wire logic            countClear,
	// results
	output logic                 stateOut,
	output logic                 risePulse,
	output iic_pkg::word_t       countOut
);
	import iic_pkg::*;
	logic        energ_reg;
	logic [22:0] timer_reg;
	logic [22:0] target;
	logic [18:0] pickMv;
	logic [18:0] dropMv;
	logic        rawState;
	// thresholds compared in mV; ac mode release is a tenth of pickup
	assign pickMv = 19'(pickupLevel) * 19'd100;
	assign dropMv = acOption ? 19'(pickupLevel) * 19'd10 : 19'(dropoutLevel) * 19'd100; // RL11
	// hysteresis: energ_reg held between the two levels
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			energ_reg <= 1'b0;
		end else if (scanTick) begin
			if (voltNow > pickMv) begin
				energ_reg <= 1'b1; // RL6
			end else if (voltNow < dropMv) begin
				energ_reg <= 1'b0; // RL7
			end // RL15
		end
	end
	assign rawState = energ_reg ^ polaritySel; // RL4
	// delay measured in 5 ms scans, rounded up
	always_comb begin
		if (rawState) begin
			target = (23'(pickupTime) + 23'd4) / 23'd5; // RL8
		end else begin
			target = (23'(dropoutTime) + 23'd4) / 23'd5 +
				(acOption ? 23'(`IIC_AC_EXTRA_MS / `IIC_SCAN_MS) : 23'd0); // RL9 RL10
		end
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stateOut  <= 1'b0;
			timer_reg <= 23'd0;
			risePulse <= 1'b0;
		end else begin
			risePulse <= 1'b0;
			if (scanTick) begin
				if (rawState == stateOut) begin
					timer_reg <= 23'd0; // RL16
				end else if (timer_reg >= target) begin // RL8 RL9
					stateOut  <= rawState;
					risePulse <= rawState;
					timer_reg <= 23'd0;
				end else begin
					timer_reg <= timer_reg + 23'd1;
				end
			end
		end
	end
	// a rise in the same cycle as a clear restarts the count at one
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			countOut <= 32'h0;
		end else if (risePulse) begin
			countOut <= countClear ? 32'h1 : countOut + 32'h1; // RL12
		end else if (countClear) begin
			countOut <= 32'h0; // RL13
		end
	end
	////////////////////////////////////////////////////////////////////////
	// checks
	state_hold_a: assert property (@(posedge core_clk) disable iff (rst) // RL3
		!scanTick |=> $stable(stateOut)) else $error("state moved between scans");
	rise_report_a: assert property (@(posedge core_clk) disable iff (rst) // RL12
		risePulse |-> (stateOut && !$past(stateOut))) else $error("rise without a change");
	count_step_a: assert property (@(posedge core_clk) disable iff (rst) // RL12
		(risePulse && !countClear) |=> countOut == $past(countOut) + 32'h1)
		else $error("count did not step");
	count_clear_a: assert property (@(posedge core_clk) disable iff (rst) // RL13
		(countClear && !risePulse) |=> countOut == 32'h0) else $error("count not cleared");
endmodule : channel_qualifier

// [sim/field_contact_model.sv]
`timescale 1ns/100ps
module field_contact_model (
	// clock and reset
	input  wire logic            core_clk,
	input  wire logic            rst,
	// contact command
	input  wire logic            setStb,
	input  wire logic [2:0]      setCh,
	input  wire iic_pkg::mvolt_t setVal,
	// line voltages, mV
	output iic_pkg::mvolt_t      voltOut [8]
);
	import iic_pkg::*;
	// open contact reads 0 V; eight separate lines
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 8; i++) voltOut[i] <= '0;
		end else if (setStb) begin
			// front end saturates at full scale
			voltOut[setCh] <= (setVal > 19'h43238) ? 19'h43238 : setVal;
		end
	end
endmodule : field_contact_model

// [sim/isolated_input_conditioner_tb.sv]
`timescale 1ns/100ps
`include "iic_params.svh"
module isolated_input_conditioner_tb;
	import iic_pkg::*;
	localparam int SCAN = 20;
	logic        core_clk = 0;
	logic        rst = 1;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        err;
	logic        irq;
	logic [7:0]  binaryInputChannel;
	logic        setStb = 0;
	logic [2:0]  setCh = '0;
	mvolt_t      setVal = '0;
	mvolt_t      voltIn [8];
	int          n_errors = 0;
	int          checked = 0;
	int          seed = 31;
	int          cycles = 0;
	int          ch;
	int          c2;
	int          c3;
	mvolt_t      v;
	////////////////////////////////////////////////////////////////
	isolated_input_conditioner #(.CHANNELS(8), .SCAN_CYC(SCAN)) u_isolated_input_conditioner (
		.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.voltIn(voltIn), .binaryInputChannel(binaryInputChannel), .irq(irq));
	field_contact_model u_field_contact_model (.core_clk(core_clk), .rst(rst),
		.setStb(setStb), .setCh(setCh), .setVal(setVal), .voltOut(voltIn));
	always #12.5 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish
	// the master waits on pready, never on a fixed count
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		@(posedge core_clk);
		while (pready !== 1'b1) begin
			@(posedge core_clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge core_clk);
	endtask : apb
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string m);
		apb(1'b0, a, 32'h0);
		check(rd, e, m);
	endtask : rdchk
	task automatic setv(input int c, input mvolt_t x);
		setStb <= 1;
		setCh <= 3'(c);
		setVal <= x;
		@(posedge core_clk);
		setStb <= 0;
	endtask : setv
	task automatic scans(input int n);
		repeat (n * SCAN) @(posedge core_clk);
	endtask : scans
	function automatic logic [11:0] at(input logic [11:0] b, input int c);
		return b + 12'(4 * c);
	endfunction : at
	function automatic logic [7:0] bit1(input int c);
		return 8'h1 << c;
	endfunction : bit1
	////////////////////////////////////////////////////////////////
	always @(posedge core_clk) begin
		cycles++;
		if (cycles > 6000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 0;
		@(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			rdchk(at(`IIC_CTRL_BASE, i), 32'h0, "ctrl reset");
			rdchk(at(`IIC_PICKUP_BASE, i), 32'h370, "pickup reset");
			rdchk(at(`IIC_DROPOUT_BASE, i), 32'h258, "dropout reset");
			rdchk(at(`IIC_PUDLY_BASE, i), 32'h0, "pickup delay reset");
			rdchk(at(`IIC_DODLY_BASE, i), 32'h0, "dropout delay reset");
			rdchk(at(`IIC_COUNT_BASE, i), 32'h0, "count reset");
		end
		apb(1'b0, 12'hffc, 32'h0);
		check(err, 1'b1, "unmapped error");
		check(rd, 32'h0, "unmapped data");
		apb(1'b1, `IIC_IRQ_MASK_OFF, 32'hff);
		ch = {$random(seed)} % 8;
		c2 = (ch + 1) % 8;
		c3 = (ch + 2) % 8;
		// strict compare: exactly at threshold stays off
		setv(ch, 19'h157c0);
		scans(3);
		check(binaryInputChannel, 8'h0, "at pickup");
		setv(ch, 19'h157c1);
		// latch, compare, report and output flop take up to four scans
		scans(4);
		check(binaryInputChannel, bit1(ch), "above pickup");
		check(irq, 1'b1, "irq raised");
		setv(ch, 19'h11170);
		scans(3);
		check(binaryInputChannel, bit1(ch), "hysteresis");
		setv(ch, 19'h0ea60);
		scans(3);
		check(binaryInputChannel, bit1(ch), "at release");
		setv(ch, 19'h0ea5f);
		scans(4);
		check(binaryInputChannel, 8'h0, "below release");
		rdchk(`IIC_IRQ_STAT_OFF, 32'(bit1(ch)), "status set");
		rdchk(`IIC_IRQ_STAT_OFF, 32'h0, "status cleared");
		check(irq, 1'b0, "irq cleared");
		apb(1'b1, `IIC_IRQ_MASK_OFF, 32'h0);
		apb(1'b1, at(`IIC_CTRL_BASE, c2), 32'h1);
		scans(3);
		check(binaryInputChannel, bit1(c2), "nc deenergized");
		check(irq, 1'b0, "irq masked");
		setv(c2, 19'h186a0);
		scans(4);
		check(binaryInputChannel, 8'h0, "nc energized");
		rdchk(`IIC_IRQ_STAT_OFF, 32'(bit1(c2)), "masked status");
		apb(1'b1, at(`IIC_PUDLY_BASE, ch), 32'd20);
		apb(1'b1, at(`IIC_DODLY_BASE, ch), 32'd20);
		setv(ch, 19'h186a0);
		scans(3);
		check(binaryInputChannel[ch], 1'b0, "pickup pending");
		setv(ch, 19'h0);
		scans(5);
		check(binaryInputChannel[ch], 1'b0, "pickup cancelled");
		setv(ch, 19'h186a0);
		scans(4);
		check(binaryInputChannel[ch], 1'b0, "pickup restarted");
		scans(4);
		check(binaryInputChannel[ch], 1'b1, "pickup done");
		setv(ch, 19'h0);
		scans(3);
		check(binaryInputChannel[ch], 1'b1, "dropout pending");
		scans(5);
		check(binaryInputChannel[ch], 1'b0, "dropout done");
		apb(1'b1, at(`IIC_CTRL_BASE, c3), 32'h2);
		setv(c3, 19'h186a0);
		scans(3);
		setv(c3, 19'h0c350);
		// long enough for a user-level release plus the ac extra delay
		scans(10);
		check(binaryInputChannel[c3], 1'b1, "ac release level");
		setv(c3, 19'h01f40);
		scans(4);
		check(binaryInputChannel[c3], 1'b1, "ac extra delay");
		scans(6);
		check(binaryInputChannel[c3], 1'b0, "ac released");
		rdchk(at(`IIC_COUNT_BASE, ch), 32'h2, "count rises");
		apb(1'b1, `IIC_CLEAR_OFF, 32'(bit1(ch)));
		rdchk(at(`IIC_COUNT_BASE, ch), 32'h0, "count cleared");
		rdchk(at(`IIC_COUNT_BASE, c3), 32'h1, "other count kept");
		v = 19'({$random(seed)} % 275001);
		setv(c2, v);
		scans(2);
		rdchk(at(`IIC_VOLT_BASE, c2), 32'(v), "voltage now");
		v = 19'({$random(seed)} % 65536);
		apb(1'b1, `IIC_OFFSET_OFF, 32'(v));
		rdchk(`IIC_OFFSET_OFF, 32'(v[15:0]), "channel offset");
		tally_and_finish();
	end
endmodule : isolated_input_conditioner_tb
